/* design/eeprom_slave.sv */
// Memory device end: two-wire bus slave over a 256-byte array with 16-byte page buffer.
// Assumes SCL, SDA, write-protect and supervisor reset are asynchronous to i_clk,
// and that i_clk is many times faster than SCL.
// Overview of operation
// - Byte write: address, word address, data, stop
// - Stop after write starts programming; ignore bus
// - Page write takes up to sixteen bytes
// - Ack each data byte, bump page offset
// - Extra bytes wrap within page, overwrite buffer
// - Written buffer entries committed in one cycle
// - No ack to address while programming
// - Master polls with write address until acked
// - Write protect: nack first data, no programming
// - Read addressed like write, direction bit one
// - Counter holds last address plus one; writes wrap within page
// - Counter wraps from 255 to zero
// - Current read: ack, one byte, nack, stop
// - Random read: dummy write, then restart read
// - Restarted read sends byte at loaded address
// - Master ack requests next byte in sequence
// - Reads increment whole address, not page
// - Master nack: release data, await stop
// - Supervisor reset aborts transfers, blocks programming start
`include "eeprom_map.svh"
module eeprom_slave
#(
  parameter int PROG_CYCLES = (`EE_PROG_TIME_NS + `EE_CLK_PERIOD_NS - 1) / `EE_CLK_PERIOD_NS,
  parameter logic [6:0] DEV_ADDR = `EE_DEV_ADDR
)
(
  input wire logic i_clk,
  input wire logic i_rst,
  twi_if.device bus,
  input wire logic i_wp,
  input wire logic i_sup_rst,
  output logic o_busy
);
  localparam int PCW = $clog2(PROG_CYCLES + 1);
  localparam int PAGE_BYTES = 1 << `EE_PAGE_W;
  localparam int NUM_PAGES = 1 << (`EE_ADDR_W - `EE_PAGE_W);
  localparam int PW = `EE_PAGE_W;
  localparam int AW = `EE_ADDR_W;
  localparam int BW = `EE_BYTE_W;

  logic [2:0] scl_sync_ff;
  logic [2:0] sda_sync_ff;
  logic [1:0] wp_sync_ff;
  logic [1:0] sup_sync_ff;
  eeprom_pkg::dev_state_type state_ff;
  eeprom_pkg::dev_state_type nxt_state;
  eeprom_pkg::byte_role_type role_ff;
  eeprom_pkg::byte_role_type nxt_role;
  logic [3:0] cnt_ff;
  logic [3:0] nxt_cnt;
  logic [BW-1:0] sh_ff;
  logic [BW-1:0] nxt_sh;
  logic [AW-1:0] addr_ff;
  logic [AW-1:0] nxt_addr;
  logic drive_ff;
  logic nxt_drive;
  logic rw_ff;
  logic nxt_rw;
  logic wr_pend_ff;
  logic nxt_wr_pend;
  logic buf_we;
  logic buf_clr;
  logic [PCW-1:0] prog_cnt_ff;
  logic [PAGE_BYTES-1:0] mask_ff;
  logic [BW-1:0] page_buf_ff [PAGE_BYTES];
  logic [BW-1:0] col_rd [PAGE_BYTES];

  // Bus event decode; stage 0 of each synchroniser only feeds stage 1
  wire scl_rise = scl_sync_ff[1] & ~scl_sync_ff[2];
  wire scl_fall = ~scl_sync_ff[1] & scl_sync_ff[2];
  wire scl_hi = scl_sync_ff[1] & scl_sync_ff[2];
  wire start_seen = scl_hi & ~sda_sync_ff[1] & sda_sync_ff[2];
  wire stop_seen = scl_hi & sda_sync_ff[1] & ~sda_sync_ff[2];
  wire sda_in = sda_sync_ff[1];
  wire sup_active = sup_sync_ff[1];
  wire busy = prog_cnt_ff != '0;
  wire byte_done = scl_fall & (cnt_ff == `EE_BITS_PER_BYTE);
  wire addr_match = sh_ff[BW-1:1] == DEV_ADDR;
  wire [PW-1:0] page_off = addr_ff[PW-1:0];
  wire [AW-PW-1:0] page_num = addr_ff[AW-1:PW];
  wire [BW-1:0] rd_byte = col_rd[page_off];
  wire commit = prog_cnt_ff == PCW'(1);
  wire prog_start = stop_seen & wr_pend_ff & ~sup_active & ~busy;
  wire [PW-1:0] off_inc = page_off + 1'h1;

  // Input synchronisers, idle levels at reset
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      scl_sync_ff <= 3'h7;
      sda_sync_ff <= 3'h7;
      wp_sync_ff <= 2'h0;
      sup_sync_ff <= 2'h0;
    end
    else
    begin
      scl_sync_ff <= {scl_sync_ff[1:0], bus.scl};
      sda_sync_ff <= {sda_sync_ff[1:0], bus.sda};
      wp_sync_ff <= {wp_sync_ff[0], i_wp};
      sup_sync_ff <= {sup_sync_ff[0], i_sup_rst};
    end
  end

  // Protocol engine: data changes only after a detected SCL fall or on supervisor reset
  always_comb
  begin
    nxt_state = state_ff;
    nxt_role = role_ff;
    nxt_cnt = cnt_ff;
    nxt_sh = sh_ff;
    nxt_addr = addr_ff;
    nxt_drive = drive_ff;
    nxt_rw = rw_ff;
    nxt_wr_pend = wr_pend_ff;
    buf_we = 1'h0;
    buf_clr = 1'h0;
    if (sup_active)
    begin
      // Abort any transfer in flight and release the line
      nxt_state = eeprom_pkg::ST_IDLE;
      nxt_drive = 1'h0;
      nxt_wr_pend = 1'h0;
    end
    else if (start_seen && !busy)
    begin
      nxt_state = eeprom_pkg::ST_RX;
      nxt_role = eeprom_pkg::ROLE_DEV;
      nxt_cnt = 4'h0;
      nxt_drive = 1'h0;
    end
    else if (stop_seen)
    begin
      nxt_state = eeprom_pkg::ST_IDLE;
      nxt_drive = 1'h0;
      nxt_wr_pend = 1'h0;
    end
    else
    begin
      case (state_ff)
        eeprom_pkg::ST_RX:
        begin
          if (scl_rise)
          begin
            nxt_sh = {sh_ff[BW-2:0], sda_in};
            nxt_cnt = cnt_ff + 4'h1;
          end
          else if (byte_done)
          begin
            nxt_cnt = 4'h0;
            nxt_state = eeprom_pkg::ST_ACK;
            nxt_drive = 1'h1;
            case (role_ff)
              eeprom_pkg::ROLE_DEV:
              begin
                nxt_rw = sh_ff[0];
                nxt_role = eeprom_pkg::ROLE_WADDR;
                if (!addr_match)
                begin
                  nxt_state = eeprom_pkg::ST_IDLE;
                  nxt_drive = 1'h0;
                end
              end
              eeprom_pkg::ROLE_WADDR:
              begin
                nxt_addr = sh_ff;
                nxt_role = eeprom_pkg::ROLE_DATA;
                buf_clr = 1'h1;
              end
              default:
              begin
                if (wp_sync_ff[1])
                begin
                  // Protected: withhold ack, never arm programming
                  nxt_state = eeprom_pkg::ST_WAIT;
                  nxt_drive = 1'h0;
                end
                else
                begin
                  buf_we = 1'h1;
                  nxt_addr = {page_num, off_inc};
                  nxt_wr_pend = 1'h1;
                end
              end
            endcase
          end
        end
        eeprom_pkg::ST_ACK:
        begin
          if (scl_fall)
          begin
            nxt_cnt = 4'h0;
            if (rw_ff)
            begin
              // First read byte comes from the current counter
              nxt_sh = rd_byte;
              nxt_addr = addr_ff + 1'h1;
              nxt_drive = ~rd_byte[BW-1];
              nxt_state = eeprom_pkg::ST_TX;
            end
            else
            begin
              nxt_drive = 1'h0;
              nxt_state = eeprom_pkg::ST_RX;
            end
          end
        end
        eeprom_pkg::ST_TX:
        begin
          if (scl_rise)
            nxt_cnt = cnt_ff + 4'h1;
          else if (byte_done)
          begin
            nxt_cnt = 4'h0;
            nxt_drive = 1'h0;
            nxt_state = eeprom_pkg::ST_RACK;
          end
          else if (scl_fall)
          begin
            nxt_sh = {sh_ff[BW-2:0], 1'h0};
            nxt_drive = ~sh_ff[BW-2];
          end
        end
        eeprom_pkg::ST_RACK:
        begin
          if (scl_rise)
          begin
            if (sda_in)
              nxt_state = eeprom_pkg::ST_WAIT;
            else
              nxt_cnt = 4'h1;
          end
          else if (scl_fall && cnt_ff == 4'h1)
          begin
            nxt_cnt = 4'h0;
            nxt_sh = rd_byte;
            nxt_addr = addr_ff + 1'h1;
            nxt_drive = ~rd_byte[BW-1];
            nxt_state = eeprom_pkg::ST_TX;
          end
        end
        eeprom_pkg::ST_WAIT: nxt_drive = 1'h0;
        eeprom_pkg::ST_IDLE: nxt_drive = 1'h0;
        default: nxt_state = eeprom_pkg::ST_IDLE;
      endcase
    end
  end

  // Engine registers and the open-drain data pin
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      state_ff <= eeprom_pkg::ST_IDLE;
      role_ff <= eeprom_pkg::ROLE_DEV;
      cnt_ff <= 4'h0;
      sh_ff <= '0;
      addr_ff <= '0;
      drive_ff <= 1'h0;
      rw_ff <= 1'h0;
      wr_pend_ff <= 1'h0;
      bus.d_sda_o <= 1'h0;
      bus.d_sda_oe_n <= 1'h1;
    end
    else
    begin
      state_ff <= nxt_state;
      role_ff <= nxt_role;
      cnt_ff <= nxt_cnt;
      sh_ff <= nxt_sh;
      addr_ff <= nxt_addr;
      drive_ff <= nxt_drive;
      rw_ff <= nxt_rw;
      wr_pend_ff <= nxt_wr_pend;
      bus.d_sda_o <= 1'h0;
      bus.d_sda_oe_n <= ~nxt_drive;
    end
  end

  // Programming timer; a running cycle survives supervisor reset
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      prog_cnt_ff <= '0;
      o_busy <= 1'h0;
    end
    else
    begin
      if (prog_start)
        prog_cnt_ff <= PCW'(PROG_CYCLES);
      else if (busy)
        prog_cnt_ff <= prog_cnt_ff - 1'h1;
      o_busy <= prog_start | (prog_cnt_ff > PCW'(1));
    end
  end

  // Per page column: buffer entry, valid bit and array storage
  genvar k;
  generate
    for (k = 0; k < PAGE_BYTES; k++)
    begin : g_col
      logic [BW-1:0] col_mem [NUM_PAGES];
      always_ff @(posedge i_clk)
      begin
        if (i_rst || buf_clr)
          mask_ff[k] <= 1'h0;
        else if (buf_we && page_off == PW'(k))
          mask_ff[k] <= 1'h1;
      end
      // Later bytes at the same offset simply overwrite the entry
      always_ff @(posedge i_clk)
      begin
        if (buf_we && page_off == PW'(k))
          page_buf_ff[k] <= sh_ff;
      end
      // All valid entries land on the same cycle
      always_ff @(posedge i_clk)
      begin
        if (commit && mask_ff[k])
          col_mem[page_num] <= page_buf_ff[k];
      end
      assign col_rd[k] = col_mem[page_num];
    end
  endgenerate
endmodule

/* design/eeprom_map.svh */
// Constants shared by both ends of the serial memory link.
// Assumes a 100 MHz system clock on both ends.
`ifndef EEPROM_MAP_SVH
`define EEPROM_MAP_SVH
`define EE_CLK_PERIOD_NS 10
`define EE_ADDR_W 8
`define EE_PAGE_W 4
`define EE_BYTE_W 8
`define EE_BITS_PER_BYTE 4'h8
`define EE_DEV_ADDR 7'h50
`define EE_PROG_TIME_NS 5000000
`define TWI_PHASE_NS 1250
`define TWI_PHASE_CYCLES ((`TWI_PHASE_NS + `EE_CLK_PERIOD_NS - 1) / `EE_CLK_PERIOD_NS)
`define TWI_FIFO_DEPTH 2
`endif

/* design/eeprom_pkg.sv */
// Types shared by the serial memory device end and the bus master end.
// Assumes nothing of its surroundings.
package eeprom_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_RACK, ST_WAIT} dev_state_type;
  typedef enum logic [1:0] {ROLE_DEV, ROLE_WADDR, ROLE_DATA} byte_role_type;
  typedef enum logic [1:0] {M_READY, M_START, M_BIT, M_STOP} mst_state_type;
  typedef enum logic [1:0] {OP_START, OP_WRITE, OP_READ, OP_STOP} mst_op_type;
endpackage

/* design/twi_if.sv */
// Two-wire link between bus master and memory device.
// Assumes each end drives its open-drain data pin as value plus low-active enable.
interface twi_if;
  logic scl;
  logic m_sda_o;
  logic m_sda_oe_n;
  logic d_sda_o;
  logic d_sda_oe_n;
  logic sda;

  // Wired-AND of both open-drain drivers, pulled up otherwise
  assign sda = ((!m_sda_oe_n && !m_sda_o) || (!d_sda_oe_n && !d_sda_o)) ? 1'h0 : 1'h1;

  modport master (output scl, output m_sda_o, output m_sda_oe_n, input sda);
  modport device (input scl, output d_sda_o, output d_sda_oe_n, input sda);
endinterface

/* design/twi_master.sv */
// Bus master end: byte-level command engine driving SCL and an open-drain SDA.
// Assumes SDA returns asynchronously; read bytes leave through a small buffer.
`include "eeprom_map.svh"
module twi_master
#(
  parameter int PHASE_CYCLES = `TWI_PHASE_CYCLES,
  parameter int FIFO_DEPTH = `TWI_FIFO_DEPTH,
  parameter int DATA_W = `EE_BYTE_W
)
(
  input wire logic i_clk,
  input wire logic i_rst,
  twi_if.master bus,
  input wire logic i_cmd_valid,
  input wire eeprom_pkg::mst_op_type i_cmd_op,
  input wire logic [DATA_W-1:0] i_cmd_data,
  input wire logic i_cmd_last,
  output logic o_cmd_ready,
  output logic o_done,
  output logic o_nack,
  output logic o_rd_valid,
  input wire logic i_rd_ready,
  output logic [DATA_W-1:0] o_rd_data
);
  localparam int TW = $clog2(PHASE_CYCLES + 1);
  localparam int CW = $clog2(FIFO_DEPTH + 1);

  eeprom_pkg::mst_state_type state_ff;
  eeprom_pkg::mst_state_type nxt_state;
  logic [1:0] sub_ff;
  logic [1:0] nxt_sub;
  logic [TW-1:0] tmr_ff;
  logic [3:0] bit_ff;
  logic [3:0] nxt_bit;
  logic [DATA_W-1:0] sh_ff;
  logic [DATA_W-1:0] nxt_sh;
  logic rd_ff;
  logic last_ff;
  logic [1:0] sda_sync_ff;
  logic [CW-1:0] cnt_ff;
  logic [DATA_W-1:0] ent_ff [FIFO_DEPTH];
  logic [DATA_W-1:0] above [FIFO_DEPTH];
  logic nxt_scl;
  logic nxt_low;

  // Handshakes and bit timing
  wire take = i_cmd_valid & o_cmd_ready;
  wire tick = tmr_ff == '0;
  wire sda_in = sda_sync_ff[1];
  wire ack_slot = bit_ff == `EE_BITS_PER_BYTE;
  wire byte_end = (state_ff == eeprom_pkg::M_BIT) & (sub_ff == 2'h2) & tick & ack_slot;
  wire push = byte_end & rd_ff;
  wire pop = o_rd_valid & i_rd_ready;
  wire [CW-1:0] nxt_cnt = cnt_ff + CW'(push) - CW'(pop);
  wire [CW-1:0] wr_idx = cnt_ff - CW'(pop);
  wire bus_idle = bus.scl & bus.m_sda_oe_n;
  wire bit_low = ack_slot ? (rd_ff & ~last_ff) : (~rd_ff & ~sh_ff[DATA_W-1]);

  // Command and phase sequencing
  always_comb
  begin
    nxt_state = state_ff;
    nxt_sub = sub_ff;
    nxt_bit = bit_ff;
    nxt_sh = sh_ff;
    if (state_ff == eeprom_pkg::M_READY)
    begin
      if (take)
      begin
        nxt_bit = 4'h0;
        nxt_sub = 2'h0;
        nxt_sh = (i_cmd_op == eeprom_pkg::OP_READ) ? '0 : i_cmd_data;
        case (i_cmd_op)
          eeprom_pkg::OP_START:
          begin
            nxt_state = eeprom_pkg::M_START;
            nxt_sub = bus_idle ? 2'h2 : 2'h0;
          end
          eeprom_pkg::OP_STOP: nxt_state = eeprom_pkg::M_STOP;
          default: nxt_state = eeprom_pkg::M_BIT;
        endcase
      end
    end
    else if (tick)
    begin
      nxt_sub = sub_ff + 2'h1;
      case (state_ff)
        eeprom_pkg::M_START:
        begin
          if (sub_ff == 2'h2)
          begin
            nxt_state = eeprom_pkg::M_BIT;
            nxt_sub = 2'h0;
          end
        end
        eeprom_pkg::M_BIT:
        begin
          if (sub_ff == 2'h2)
          begin
            nxt_sub = 2'h0;
            nxt_bit = bit_ff + 4'h1;
            if (!ack_slot)
              nxt_sh = {sh_ff[DATA_W-2:0], sda_in};
            else
              nxt_state = eeprom_pkg::M_READY;
          end
        end
        eeprom_pkg::M_STOP:
        begin
          if (sub_ff == 2'h2)
            nxt_state = eeprom_pkg::M_READY;
        end
        default: nxt_state = eeprom_pkg::M_READY;
      endcase
    end
  end

  // Pin levels follow the phase being entered
  always_comb
  begin
    nxt_scl = bus.scl;
    nxt_low = ~bus.m_sda_oe_n;
    case (nxt_state)
      eeprom_pkg::M_START:
      begin
        nxt_scl = nxt_sub != 2'h0;
        nxt_low = nxt_sub == 2'h2;
      end
      eeprom_pkg::M_BIT:
      begin
        nxt_scl = nxt_sub == 2'h2;
        if (nxt_sub != 2'h0)
          nxt_low = bit_low;
      end
      eeprom_pkg::M_STOP:
      begin
        nxt_scl = nxt_sub != 2'h0;
        nxt_low = nxt_sub != 2'h2;
      end
      default:
      begin
        // Park SCL low after a byte so a restart makes a clean edge
        if (state_ff == eeprom_pkg::M_BIT)
          nxt_scl = 1'h0;
        nxt_low = 1'h0;
      end
    endcase
  end

  // Sequencer and pin registers
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      state_ff <= eeprom_pkg::M_READY;
      sub_ff <= 2'h0;
      tmr_ff <= '0;
      bit_ff <= 4'h0;
      sh_ff <= '0;
      rd_ff <= 1'h0;
      last_ff <= 1'h0;
      sda_sync_ff <= 2'h3;
      bus.scl <= 1'h1;
      bus.m_sda_o <= 1'h0;
      bus.m_sda_oe_n <= 1'h1;
    end
    else
    begin
      state_ff <= nxt_state;
      sub_ff <= nxt_sub;
      tmr_ff <= (take || tick) ? TW'(PHASE_CYCLES - 1) : tmr_ff - 1'h1;
      bit_ff <= nxt_bit;
      sh_ff <= nxt_sh;
      if (take)
      begin
        rd_ff <= i_cmd_op == eeprom_pkg::OP_READ;
        last_ff <= i_cmd_last;
      end
      sda_sync_ff <= {sda_sync_ff[0], bus.sda};
      bus.scl <= nxt_scl;
      bus.m_sda_o <= 1'h0;
      bus.m_sda_oe_n <= ~nxt_low;
    end
  end

  // Status outputs; ready withheld while the read buffer is full
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_cmd_ready <= 1'h0;
      o_done <= 1'h0;
      o_nack <= 1'h0;
      o_rd_valid <= 1'h0;
      cnt_ff <= '0;
    end
    else
    begin
      o_cmd_ready <= (nxt_state == eeprom_pkg::M_READY) && !take
                     && (nxt_cnt < CW'(FIFO_DEPTH));
      o_done <= byte_end;
      if (byte_end)
        o_nack <= sda_in;
      o_rd_valid <= nxt_cnt != '0;
      cnt_ff <= nxt_cnt;
    end
  end

  // Read buffer entries shift toward the head on each pop
  genvar e;
  generate
    for (e = 0; e < FIFO_DEPTH; e++)
    begin : g_ent
      if (e == FIFO_DEPTH - 1)
      begin : g_top
        assign above[e] = '0;
      end
      else
      begin : g_mid
        assign above[e] = ent_ff[e + 1];
      end
      always_ff @(posedge i_clk)
      begin
        if (push && wr_idx == CW'(e))
          ent_ff[e] <= sh_ff;
        else if (pop)
          ent_ff[e] <= above[e];
      end
    end
  endgenerate
  assign o_rd_data = ent_ff[0];
endmodule

/* test/eeprom_link_asserts.sv */
// Concurrent checks on the two-wire link between master end and memory end.
// Assumes instantiation beside the link, on the shared system clock, PHASE_CYCLES of 20.
module eeprom_link_asserts
#(
  parameter int PROG_CYCLES = 500000
)
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic scl,
  input wire logic sda,
  input wire logic d_sda_o,
  input wire logic d_sda_oe_n,
  input wire logic o_busy,
  input wire logic i_wp,
  input wire logic i_sup_rst
);
  timeunit 1ns;
  timeprecision 1ps;
  int busy_cnt_ff;
  int nxt_busy_cnt;
  logic [7:0] since_stop_ff;
  logic [7:0] nxt_since_stop;
  logic sda_ff;
  logic stop_seen;

  // Stop is SDA rising with SCL high; counter saturates so it never wraps
  assign stop_seen = scl && sda && !sda_ff;
  assign nxt_busy_cnt = o_busy ? busy_cnt_ff + 1 : 0;
  assign nxt_since_stop = stop_seen ? 8'h00 :
    (since_stop_ff == 8'hFF) ? 8'hFF : since_stop_ff + 8'h01;

  // Helper state
  always_ff @(posedge i_clk)
  begin
    busy_cnt_ff <= i_rst ? 0 : nxt_busy_cnt;
    since_stop_ff <= i_rst ? 8'hFF : nxt_since_stop;
    sda_ff <= i_rst ? 1'h1 : sda;
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  chk_sda_scl_low: assert property ($changed(d_sda_oe_n) |-> !scl)
    else $error("memory end moved SDA while SCL high");
  chk_drive_low_only: assert property (!d_sda_oe_n |-> d_sda_o == 1'h0)
    else $error("memory end drives SDA high");
  chk_busy_silent: assert property (o_busy |-> d_sda_oe_n)
    else $error("memory end answered while programming");
  chk_prog_length: assert property ($fell(o_busy) |-> busy_cnt_ff == PROG_CYCLES)
    else $error("programming time wrong");
  chk_busy_after_stop: assert property ($rose(o_busy) |-> since_stop_ff <= 8'h10)
    else $error("programming began without a stop");
  chk_wp_no_prog: assert property (i_wp && $past(i_wp, 8) |-> !$rose(o_busy))
    else $error("programming under write protect");
  chk_sup_rst_idle: assert property (i_sup_rst && $past(i_sup_rst, 4) |->
    d_sda_oe_n && !$rose(o_busy))
    else $error("activity during supervisor reset");
  // Longest legal low drive is a zero byte plus a stalled bit at 20-cycle phases
  chk_release_bound: assert property ($fell(d_sda_oe_n) |-> ##[1:600] d_sda_oe_n)
    else $error("memory end held SDA too long");
endmodule

/* test/test_serial_eeprom_access_engine.sv */
// Bench joining master end and memory end over the link interface.
// Assumes design/ on the include path; all traffic goes through the master command port.
module test_serial_eeprom_access_engine;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PROG = 1500;
  `define CHECK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
$display("[ERR] %s expected %0h seen %0h", nm, e, g); end end
  logic i_clk, i_rst, i_wp, i_sup_rst, busy;
  logic cmd_valid, cmd_last, cmd_ready, done, nack, rd_valid, rd_ready, last_nack;
  eeprom_pkg::mst_op_type cmd_op;
  logic [7:0] cmd_data, rd_data;
  logic [7:0] exp_mem [256];
  int n_checks, bad_count;
  twi_if link();

  twi_master #(.PHASE_CYCLES(20)) i_twi_master (.i_clk(i_clk), .i_rst(i_rst), .bus(link),
    .i_cmd_valid(cmd_valid), .i_cmd_op(cmd_op), .i_cmd_data(cmd_data), .i_cmd_last(cmd_last),
    .o_cmd_ready(cmd_ready), .o_done(done), .o_nack(nack), .o_rd_valid(rd_valid),
    .i_rd_ready(rd_ready), .o_rd_data(rd_data));
  eeprom_slave #(.PROG_CYCLES(PROG)) i_eeprom_slave (.i_clk(i_clk), .i_rst(i_rst), .bus(link),
    .i_wp(i_wp), .i_sup_rst(i_sup_rst), .o_busy(busy));
  eeprom_link_asserts #(.PROG_CYCLES(PROG)) i_link_asserts (.i_clk(i_clk), .i_rst(i_rst),
    .scl(link.scl), .sda(link.sda), .d_sda_o(link.d_sda_o), .d_sda_oe_n(link.d_sda_oe_n),
    .o_busy(busy), .i_wp(i_wp), .i_sup_rst(i_sup_rst));

  // 100 MHz system clock
  initial
  begin
    i_clk = 1'h0;
    forever #5 i_clk = ~i_clk;
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic test_end(input string nm);
    $display("test %s finished, %0d mismatches so far", nm, bad_count);
  endtask

  // Request held until ready is seen; readiness judged at negedge, stable to the take edge
  task automatic cmd(input eeprom_pkg::mst_op_type op, input logic [7:0] d, input logic lst);
    @(posedge i_clk);
    cmd_valid <= 1'h1;
    cmd_op <= op;
    cmd_data <= d;
    cmd_last <= lst;
    @(negedge i_clk);
    for (int i = 0; i < 4000 && cmd_ready !== 1'h1; i++)
      @(negedge i_clk);
    @(posedge i_clk);
    cmd_valid <= 1'h0;
    if (op != eeprom_pkg::OP_STOP)
    begin
      @(negedge i_clk);
      for (int i = 0; i < 4000 && done !== 1'h1; i++)
        @(negedge i_clk);
      `CHECK("byte done", 1'h1, done)
      last_nack = nack;
    end
  endtask

  task automatic start_b(input logic [7:0] b, input logic e);
    cmd(eeprom_pkg::OP_START, b, 1'h0);
    `CHECK("address ack", e, last_nack)
  endtask

  task automatic wr(input logic [7:0] b, input logic e);
    cmd(eeprom_pkg::OP_WRITE, b, 1'h0);
    `CHECK("data ack", e, last_nack)
  endtask

  task automatic stop_b();
    cmd(eeprom_pkg::OP_STOP, 8'h00, 1'h0);
  endtask

  // Pop one byte from the read buffer and compare with the model
  task automatic pop(input logic [7:0] a);
    @(negedge i_clk);
    for (int i = 0; i < 4000 && rd_valid !== 1'h1; i++)
      @(negedge i_clk);
    `CHECK("read valid", 1'h1, rd_valid)
    `CHECK("read byte", exp_mem[a], rd_data)
    @(posedge i_clk);
    rd_ready <= 1'h1;
    @(posedge i_clk);
    rd_ready <= 1'h0;
  endtask

  // Polls with write addressing; the first try must fall inside programming
  task automatic poll();
    start_b(8'hA0, 1'h1);
    stop_b();
    for (int i = 0; i < 20 && last_nack !== 1'h0; i++)
    begin
      cmd(eeprom_pkg::OP_START, 8'hA0, 1'h0);
      stop_b();
    end
    `CHECK("poll ack", 1'h0, last_nack)
  endtask

  // Offset wraps in the low four bits, so the model does the same
  task automatic write_seq(input logic [7:0] a, input int n);
    start_b(8'hA0, 1'h0);
    wr(a, 1'h0);
    for (int i = 0; i < n; i++)
    begin
      exp_mem[{a[7:4], a[3:0] + i[3:0]}] = 8'h30 + i[7:0];
      wr(8'h30 + i[7:0], 1'h0);
    end
    stop_b();
    // The stop itself spans three phases after it is taken
    repeat (80) @(negedge i_clk);
    `CHECK("busy after stop", 1'h1, busy)
    poll();
  endtask

  task automatic addr_rd(input logic [7:0] a);
    start_b(8'hA0, 1'h0);
    wr(a, 1'h0);
    start_b(8'hA1, 1'h0);
  endtask

  // With stall set, two bytes fill the buffer and the master must hold off
  task automatic read_run(input logic [7:0] a, input int n, input logic stall);
    int k;
    k = 0;
    if (stall)
    begin
      cmd(eeprom_pkg::OP_READ, 8'h00, 1'h0);
      cmd(eeprom_pkg::OP_READ, 8'h00, 1'h0);
      repeat (50) @(negedge i_clk);
      `CHECK("ready while full", 1'h0, cmd_ready)
      pop(a);
      pop(a + 8'h01);
      k = 2;
    end
    for (int i = k; i < n; i++)
    begin
      cmd(eeprom_pkg::OP_READ, 8'h00, i == n - 1);
      pop(a + i[7:0]);
    end
    stop_b();
  endtask

  task automatic t_page_wrap();
    write_seq(8'hFF, 17);
    write_seq(8'h00, 1);
    test_end("page write wrap");
  endtask

  task automatic t_reads();
    addr_rd(8'hF5);
    read_run(8'hF5, 1, 1'h0);
    start_b(8'hA1, 1'h0);
    read_run(8'hF6, 1, 1'h0);
    addr_rd(8'hFE);
    read_run(8'hFE, 3, 1'h1);
    test_end("reads");
  endtask

  // Wait covers the stop's own three phases, so a wrong start would show
  task automatic t_protect();
    @(posedge i_clk);
    i_wp <= 1'h1;
    repeat (4) @(posedge i_clk);
    start_b(8'hA0, 1'h0);
    wr(8'hF3, 1'h0);
    wr(8'h99, 1'h1);
    stop_b();
    repeat (80) @(negedge i_clk);
    `CHECK("busy under protect", 1'h0, busy)
    @(posedge i_clk);
    i_wp <= 1'h0;
    addr_rd(8'hF3);
    read_run(8'hF3, 1, 1'h0);
    test_end("write protect");
  endtask

  // Abort a pending write, then refuse a start while held
  task automatic t_supervisor();
    start_b(8'hA0, 1'h0);
    wr(8'hF0, 1'h0);
    wr(8'h77, 1'h0);
    @(posedge i_clk);
    i_sup_rst <= 1'h1;
    repeat (4) @(posedge i_clk);
    stop_b();
    repeat (80) @(negedge i_clk);
    `CHECK("busy after abort", 1'h0, busy)
    start_b(8'hA0, 1'h1);
    stop_b();
    @(posedge i_clk);
    i_sup_rst <= 1'h0;
    repeat (4) @(posedge i_clk);
    start_b(8'hA2, 1'h1);
    stop_b();
    addr_rd(8'hF0);
    read_run(8'hF0, 1, 1'h0);
    test_end("supervisor reset");
  endtask

  // Main sequence
  initial
  begin
    i_rst = 1'h1;
    cmd_valid = 1'h0;
    cmd_op = eeprom_pkg::OP_STOP;
    cmd_data = 8'h00;
    cmd_last = 1'h0;
    rd_ready = 1'h0;
    i_wp = 1'h0;
    i_sup_rst = 1'h0;
    n_checks = 0;
    bad_count = 0;
    repeat (8) @(posedge i_clk);
    i_rst <= 1'h0;
    repeat (4) @(posedge i_clk);
    t_page_wrap();
    t_reads();
    t_protect();
    t_supervisor();
    print_verdict();
  end

  // Run needs about 35k cycles; a hang ends here
  initial
  begin
    repeat (90000) @(posedge i_clk);
    bad_count++;
    print_verdict();
  end
endmodule
